// [src/isx_exec.sv]
// Execute slice for increment-skip-nonzero and the two OR instructions.
// Assumes the fetch pipeline presents one instruction word per cycle and the
// data memory returns read data on the clock after its read strobe.
`timescale 1ns/1ps
module isx_exec (
  input wire logic CORE_CLK, // Core clock, 125 MHz
  input wire logic RST_N, // Asynchronous reset, active low
  input wire logic INSTR_VALID, // Fetched word is present
  input wire logic [15:0] INSTR_WORD, // Fetched instruction word
  input wire logic NEXT_TWO_WORD, // Word behind the current one starts a two-word op
  input wire logic EXT_SET_EN, // Extended instruction set enabled
  input wire logic [3:0] BANK_SEL, // bank_select_register value
  input wire logic [11:0] INDEX_BASE, // Base pointer for literal-offset mode
  input wire logic [7:0] MEM_RDATA, // Data memory read data
  output logic INSTR_TAKE, // Word taken this phase
  output logic [11:0] MEM_ADDR, // Data memory address
  output logic MEM_RD, // Data memory read strobe
  output logic MEM_WR, // Data memory write strobe
  output logic [7:0] MEM_WDATA, // Data memory write data
  output logic [7:0] ACC, // Working accumulator
  output logic FLAG_N, // negative_flag
  output logic FLAG_Z, // zero_flag
  output logic SKIP_ACTIVE, // Current cycle is a forced no-operation
  output logic OP_DONE // Instruction retires this phase
);

  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rst_n_int;
  isx_pkg::isx_phase_t phase_reg;
  isx_pkg::isx_phase_t phase_next;
  isx_pkg::isx_op_t op_reg;
  isx_pkg::isx_op_t op_next;
  logic dest_reg;
  logic [7:0] lit_reg;
  logic [11:0] addr_reg;
  logic rd_reg;
  logic wr_reg;
  logic [7:0] res_reg;
  logic [7:0] res_next;
  logic [7:0] acc_reg;
  logic n_reg;
  logic z_reg;
  logic [1:0] skip_reg;
  logic nop_reg;
  logic done_reg;
  logic [11:0] addr_next;
  logic take;

  // Reset release through two flops so no flop leaves reset on a torn edge
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rst_n_int = rst_sync2_reg;

  // Operand address for the word being decoded
  isx_addr u_addr (
    .file_addr(INSTR_WORD[7:0]),
    .access_sel(INSTR_WORD[isx_pkg::ISX_A_BIT]),
    .ext_en(EXT_SET_EN),
    .bank_sel(BANK_SEL),
    .index_base(INDEX_BASE),
    .addr(addr_next),
    .indexed()
  );

  // Phase sequencer, four clocks per instruction cycle
  always_comb begin
    unique case (phase_reg)
      isx_pkg::ISX_Q1: phase_next = isx_pkg::ISX_Q2;
      isx_pkg::ISX_Q2: phase_next = isx_pkg::ISX_Q3;
      isx_pkg::ISX_Q3: phase_next = isx_pkg::ISX_Q4;
      isx_pkg::ISX_Q4: phase_next = isx_pkg::ISX_Q1;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      phase_reg <= isx_pkg::ISX_Q1;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // A word is consumed only in Q1; a missing word leaves an idle cycle.
  // Held off while the internal reset stands, else a word would be lost
  assign take = rst_n_int && (phase_reg == isx_pkg::ISX_Q1) && INSTR_VALID;

  // Decode; other opcodes fall to no-operation here
  always_comb begin
    op_next = isx_pkg::ISX_NONE;
    if (INSTR_WORD[15:8] == isx_pkg::ISX_OP_OR_LIT) begin
      op_next = isx_pkg::ISX_ORL;
    end else if (INSTR_WORD[isx_pkg::ISX_OP6_MSB:isx_pkg::ISX_OP6_LSB]
                 == isx_pkg::ISX_OP_OR_FILE) begin
      op_next = isx_pkg::ISX_ORF;
    end else if (INSTR_WORD[isx_pkg::ISX_OP6_MSB:isx_pkg::ISX_OP6_LSB]
                 == isx_pkg::ISX_OP_INC_SNZ) begin
      op_next = isx_pkg::ISX_INC;
    end
  end

  // Capture the instruction; a pending skip turns the word into a no-operation
  always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      op_reg <= isx_pkg::ISX_NONE;
      dest_reg <= 1'b0;
      lit_reg <= 8'h00;
      addr_reg <= 12'h000;
      nop_reg <= 1'b0;
    end else if (phase_reg == isx_pkg::ISX_Q1) begin
      if (take && (skip_reg == isx_pkg::ISX_SKIP_RESET)) begin
        op_reg <= op_next;
        dest_reg <= INSTR_WORD[isx_pkg::ISX_D_BIT];
        lit_reg <= INSTR_WORD[7:0];
        addr_reg <= addr_next;
        nop_reg <= 1'b0;
      end else begin
        op_reg <= isx_pkg::ISX_NONE;
        nop_reg <= take;
      end
    end
  end

  // Read strobe stands through Q2 for file operands
  always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      rd_reg <= 1'b0;
    end else begin
      rd_reg <= (phase_reg == isx_pkg::ISX_Q1) && take
                && (skip_reg == isx_pkg::ISX_SKIP_RESET)
                && ((op_next == isx_pkg::ISX_INC) || (op_next == isx_pkg::ISX_ORF));
    end
  end

  // Process data; the memory answer is valid in Q3
  always_comb begin
    unique case (op_reg)
      isx_pkg::ISX_INC: res_next = MEM_RDATA + 8'h01;
      isx_pkg::ISX_ORL: res_next = acc_reg | lit_reg;
      isx_pkg::ISX_ORF: res_next = acc_reg | MEM_RDATA;
      isx_pkg::ISX_NONE: res_next = 8'h00;
    endcase
  end

  // Result and write strobe for Q4
  always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      res_reg <= 8'h00;
      wr_reg <= 1'b0;
    end else if (phase_reg == isx_pkg::ISX_Q3) begin
      res_reg <= res_next;
      wr_reg <= dest_reg && ((op_reg == isx_pkg::ISX_INC)
                || (op_reg == isx_pkg::ISX_ORF));
    end else if (phase_reg == isx_pkg::ISX_Q4) begin
      wr_reg <= 1'b0;
    end
  end

  // Accumulator written at the close of Q4
  always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      acc_reg <= isx_pkg::ISX_ACC_RESET;
    end else if (phase_reg == isx_pkg::ISX_Q4) begin
      if (op_reg == isx_pkg::ISX_ORL) begin
        acc_reg <= res_reg;
      end else if (!dest_reg && (op_reg != isx_pkg::ISX_NONE)) begin
        acc_reg <= res_reg;
      end
    end
  end

  // Only the OR forms touch flags; carry and overflow live elsewhere untouched
  always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      n_reg <= 1'b0;
      z_reg <= 1'b0;
    end else if ((phase_reg == isx_pkg::ISX_Q4)
                 && ((op_reg == isx_pkg::ISX_ORL) || (op_reg == isx_pkg::ISX_ORF))) begin
      n_reg <= res_reg[7];
      z_reg <= (res_reg == 8'h00);
    end
  end

  // Skip budget: one cycle, or two when the discarded word opens a two-word op
  always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      skip_reg <= isx_pkg::ISX_SKIP_RESET;
    end else if ((phase_reg == isx_pkg::ISX_Q4) && (op_reg == isx_pkg::ISX_INC)
                 && (res_reg != 8'h00)) begin
      skip_reg <= NEXT_TWO_WORD ? isx_pkg::ISX_SKIP_TWO_WORD
                                : isx_pkg::ISX_SKIP_ONE_WORD;
    end else if (take && (skip_reg != isx_pkg::ISX_SKIP_RESET)) begin
      skip_reg <= skip_reg - 2'h1;
    end
  end

  // Retire marker stands through Q4 of every taken word except an undecoded opcode outside a skip, which retires nothing
  always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (phase_reg == isx_pkg::ISX_Q3)
                  && ((op_reg != isx_pkg::ISX_NONE) || nop_reg);
    end
  end

  // Outputs
  assign INSTR_TAKE = take;
  assign MEM_ADDR = addr_reg;
  assign MEM_RD = rd_reg;
  assign MEM_WR = wr_reg;
  assign MEM_WDATA = res_reg;
  assign ACC = acc_reg;
  assign FLAG_N = n_reg;
  assign FLAG_Z = z_reg;
  assign SKIP_ACTIVE = nop_reg;
  assign OP_DONE = done_reg;

endmodule

// [src/isx_pkg.sv]
// Constants, opcode layouts and types for the increment-skip / OR execute slice.
// Assumes an 8-bit core with a 12-bit data address space and four phases per cycle.
package isx_pkg;

  // Opcode fields in the upper byte of the instruction word
  localparam logic [7:0] ISX_OP_OR_LIT = 8'h09;
  localparam logic [5:0] ISX_OP_OR_FILE = 6'h04;
  localparam logic [5:0] ISX_OP_INC_SNZ = 6'h12;
  localparam int ISX_OP6_MSB = 15;
  localparam int ISX_OP6_LSB = 10;
  localparam int ISX_D_BIT = 9;
  localparam int ISX_A_BIT = 8;

  // Addressing constants
  localparam logic [7:0] ISX_INDEX_LIMIT = 8'h5f;
  localparam logic [3:0] ISX_ACCESS_HIGH_BANK = 4'hf;
  localparam logic [3:0] ISX_ACCESS_LOW_BANK = 4'h0;

  // Reset values
  localparam logic [7:0] ISX_ACC_RESET = 8'h00;
  localparam logic [1:0] ISX_SKIP_RESET = 2'h0;

  // Skip lengths in whole instruction cycles
  localparam logic [1:0] ISX_SKIP_ONE_WORD = 2'h1;
  localparam logic [1:0] ISX_SKIP_TWO_WORD = 2'h2;

  // Four clock phases form one instruction cycle
  typedef enum logic [1:0] {
    ISX_Q1,
    ISX_Q2,
    ISX_Q3,
    ISX_Q4
  } isx_phase_t;

  // Operation held for the current instruction cycle
  typedef enum logic [1:0] {
    ISX_NONE,
    ISX_INC,
    ISX_ORL,
    ISX_ORF
  } isx_op_t;

endpackage

// [src/isx_addr.sv]
// Operand address resolver for the byte-oriented file instructions.
// Assumes bank_select and the index base come settled from the same clock domain.
`timescale 1ns/1ps
module isx_addr (
  input wire logic [7:0] file_addr, // 8-bit file field of the opcode
  input wire logic access_sel, // a bit: 0 access bank, 1 banked
  input wire logic ext_en, // Extended instruction set enabled
  input wire logic [3:0] bank_sel, // bank_select_register value
  input wire logic [11:0] index_base, // Base pointer for literal-offset mode
  output logic [11:0] addr, // Resolved data address
  output logic indexed // Operand uses literal-offset mode
);

  // Literal-offset mode only covers the low part of the access window
  always_comb begin
    indexed = ext_en && !access_sel && (file_addr <= isx_pkg::ISX_INDEX_LIMIT);
    if (indexed) begin
      addr = 12'(index_base + {4'h0, file_addr}); // Wraps inside data space
    end else if (access_sel) begin
      addr = {bank_sel, file_addr};
    end else if (file_addr <= isx_pkg::ISX_INDEX_LIMIT) begin
      addr = {isx_pkg::ISX_ACCESS_LOW_BANK, file_addr};
    end else begin
      addr = {isx_pkg::ISX_ACCESS_HIGH_BANK, file_addr};
    end
  end

endmodule

// [tb/isx_exec_chk.sv]
// Concurrent checks on the execute slice ports.
// Assumes one clock domain; bound to every isx_exec instance.
`timescale 1ns/1ps
module isx_exec_chk (
  input wire logic CORE_CLK, // Core clock
  input wire logic RST_N, // Reset, active low
  input wire logic INSTR_TAKE, // Word taken
  input wire logic MEM_RD, // Read strobe
  input wire logic MEM_WR, // Write strobe
  input wire logic [7:0] MEM_WDATA, // Write data
  input wire logic [7:0] ACC, // Accumulator
  input wire logic FLAG_N, // negative_flag
  input wire logic FLAG_Z, // zero_flag
  input wire logic SKIP_ACTIVE, // Forced no-operation
  input wire logic OP_DONE // Retire pulse
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // Reads always retire two clocks later
  property p_rd_done; MEM_RD |-> ##2 OP_DONE; endproperty
  a_rd_done: assert property (p_rd_done) else $error("read not retired");
  property p_wr_rd; MEM_WR |-> $past(MEM_RD, 2) && OP_DONE; endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("write without read");
  // A discarded word touches nothing
  property p_nop; SKIP_ACTIVE |-> !MEM_RD && !MEM_WR; endproperty
  a_nop: assert property (p_nop) else $error("memory access in skip");
  property p_skip_hold;
    SKIP_ACTIVE && $past(SKIP_ACTIVE) |-> $stable(ACC) && $stable(FLAG_N) && $stable(FLAG_Z);
  endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("state changed in skip");
  property p_acc_when; $changed(ACC) |-> $past(OP_DONE); endproperty
  a_acc_when: assert property (p_acc_when) else $error("accumulator off cycle");
  // Flags follow the written result, accumulator or file
  property p_flag_acc;
    ($changed(FLAG_Z) || $changed(FLAG_N)) && !$past(MEM_WR)
      |-> FLAG_Z == (ACC == 8'h00) && FLAG_N == ACC[7];
  endproperty
  a_flag_acc: assert property (p_flag_acc) else $error("flags differ from acc");
  property p_flag_file;
    ($changed(FLAG_Z) || $changed(FLAG_N)) && $past(MEM_WR)
      |-> FLAG_Z == ($past(MEM_WDATA) == 8'h00) && FLAG_N == $past(MEM_WDATA[7]);
  endproperty
  a_flag_file: assert property (p_flag_file) else $error("flags differ from file");
  property p_done_gap; OP_DONE |=> !OP_DONE [*3]; endproperty
  a_done_gap: assert property (p_done_gap) else $error("retire too soon");
  property p_take_gap; INSTR_TAKE |=> !INSTR_TAKE [*3]; endproperty
  a_take_gap: assert property (p_take_gap) else $error("words too close");
  c_skip: cover property ($rose(SKIP_ACTIVE));
  c_wr: cover property (MEM_WR);
  c_zero: cover property ($rose(FLAG_Z));
endmodule
bind isx_exec isx_exec_chk isx_exec_chk_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
  .INSTR_TAKE(INSTR_TAKE), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA),
  .ACC(ACC), .FLAG_N(FLAG_N), .FLAG_Z(FLAG_Z), .SKIP_ACTIVE(SKIP_ACTIVE), .OP_DONE(OP_DONE));

// [tb/isx_mem_model.sv]
// Data memory behind the execute slice, one clock read latency.
// Assumes the bench preloads cells through the mem array.
`timescale 1ns/1ps
module isx_mem_model (
  input wire logic clk, // Core clock
  input wire logic [11:0] mem_addr, // Address
  input wire logic mem_rd, // Read strobe
  input wire logic mem_wr, // Write strobe
  input wire logic [7:0] mem_wdata, // Write data
  output logic [7:0] mem_rdata // Read data
);
  logic [7:0] mem [0:4095];
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    mem_rdata = 8'h00;
  end
  // Stale data toggles each clock so a sample one clock late never looks right
  always @(posedge clk) begin
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end
endmodule

// [tb/inc_skip_and_or_exec_tb.sv]
// Self-checking bench for the execute slice with a memory model.
// Assumes one word per instruction cycle, taken while INSTR_TAKE is high.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module inc_skip_and_or_exec_tb;
  logic CORE_CLK = 0, RST_N = 0, INSTR_VALID = 0, NEXT_TWO_WORD = 0, EXT_SET_EN = 0;
  logic [15:0] INSTR_WORD = 16'h0000;
  logic [3:0] BANK_SEL = 4'h0;
  logic [11:0] INDEX_BASE = 12'h000, MEM_ADDR, adr;
  logic [7:0] MEM_RDATA, MEM_WDATA, ACC;
  logic INSTR_TAKE, MEM_RD, MEM_WR, FLAG_N, FLAG_Z, SKIP_ACTIVE, OP_DONE, sk;
  int bad_count = 0, n_compared = 0;
  isx_exec isx_exec_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .INSTR_VALID(INSTR_VALID),
    .INSTR_WORD(INSTR_WORD), .NEXT_TWO_WORD(NEXT_TWO_WORD), .EXT_SET_EN(EXT_SET_EN),
    .BANK_SEL(BANK_SEL), .INDEX_BASE(INDEX_BASE), .MEM_RDATA(MEM_RDATA),
    .INSTR_TAKE(INSTR_TAKE), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
    .MEM_WDATA(MEM_WDATA), .ACC(ACC), .FLAG_N(FLAG_N), .FLAG_Z(FLAG_Z),
    .SKIP_ACTIVE(SKIP_ACTIVE), .OP_DONE(OP_DONE));
  isx_mem_model isx_mem_model_i (.clk(CORE_CLK), .mem_addr(MEM_ADDR), .mem_rd(MEM_RD),
    .mem_wr(MEM_WR), .mem_wdata(MEM_WDATA), .mem_rdata(MEM_RDATA));
  initial begin
    forever #4 CORE_CLK = ~CORE_CLK;
  end
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Issue one word, wait for its retire pulse, note skip and address
  task automatic run(input logic [15:0] w);
    int i;
    @(posedge CORE_CLK);
    INSTR_WORD <= w;
    INSTR_VALID <= 1'b1;
    i = 0;
    @(negedge CORE_CLK);
    while (INSTR_TAKE !== 1'b1 && i < 20) begin @(negedge CORE_CLK); i++; end
    @(posedge CORE_CLK);
    INSTR_VALID <= 1'b0;
    i = 0;
    @(negedge CORE_CLK);
    while (OP_DONE !== 1'b1 && i < 8) begin @(negedge CORE_CLK); i++; end
    `CHK("retire", 1'b1, OP_DONE)
    sk = SKIP_ACTIVE;
    adr = MEM_ADDR;
  endtask
  task automatic st(input logic [7:0] a, input logic n, input logic z);
    @(negedge CORE_CLK);
    `CHK("acc", a, ACC)
    `CHK("neg", n, FLAG_N)
    `CHK("zero", z, FLAG_Z)
  endtask
  task automatic t_orl();
    run(16'h0900); st(8'h00, 1'b0, 1'b1);
    run(16'h099a); st(8'h9a, 1'b1, 1'b0);
    run(16'h0935); st(8'hbf, 1'b1, 1'b0);
  endtask
  task automatic t_orf();
    isx_mem_model_i.mem[12'h310] = 8'h40;
    run(16'h1110); st(8'hff, 1'b1, 1'b0);
    `CHK("bank addr", 12'h310, adr)
    isx_mem_model_i.mem[12'h310] = 8'h00;
    run(16'h1310); st(8'hff, 1'b1, 1'b0);
    `CHK("file", 8'hff, isx_mem_model_i.mem[12'h310])
  endtask
  task automatic t_inc();
    isx_mem_model_i.mem[12'h020] = 8'hff;
    run(16'h4a20); st(8'hff, 1'b1, 1'b0);
    `CHK("access addr", 12'h020, adr)
    `CHK("wrap", 8'h00, isx_mem_model_i.mem[12'h020])
    run(16'h0900); `CHK("zero no skip", 1'b0, sk)
    run(16'h4820); st(8'h01, 1'b1, 1'b0);
    run(16'h0980); `CHK("skip", 1'b1, sk)
    st(8'h01, 1'b1, 1'b0);
    run(16'h0902); `CHK("resume", 1'b0, sk)
    st(8'h03, 1'b0, 1'b0);
  endtask
  task automatic t_two();
    isx_mem_model_i.mem[12'hf80] = 8'h05;
    @(posedge CORE_CLK);
    NEXT_TWO_WORD <= 1'b1;
    run(16'h4a80); st(8'h03, 1'b0, 1'b0);
    `CHK("high access", 12'hf80, adr)
    `CHK("inc file", 8'h06, isx_mem_model_i.mem[12'hf80])
    run(16'h0940); `CHK("skip 1", 1'b1, sk)
    @(posedge CORE_CLK);
    NEXT_TWO_WORD <= 1'b0;
    run(16'h0940); `CHK("skip 2", 1'b1, sk)
    st(8'h03, 1'b0, 1'b0);
    run(16'h0940); `CHK("after", 1'b0, sk)
    st(8'h43, 1'b0, 1'b0);
  endtask
  task automatic t_idx();
    @(posedge CORE_CLK);
    EXT_SET_EN <= 1'b1;
    INDEX_BASE <= 12'h200;
    isx_mem_model_i.mem[12'h25f] = 8'h10;
    run(16'h105f); `CHK("indexed", 12'h25f, adr)
    st(8'h53, 1'b0, 1'b0);
    run(16'h1060); `CHK("above limit", 12'hf60, adr)
    run(16'h1120); `CHK("banked", 12'h320, adr)
    isx_mem_model_i.mem[12'h321] = 8'h80;
    run(16'h1321); st(8'h53, 1'b1, 1'b0);
    `CHK("file or", 8'hd3, isx_mem_model_i.mem[12'h321])
  endtask
  initial begin
    repeat (20) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    BANK_SEL <= 4'h3;
    t_orl();
    t_orf();
    t_inc();
    t_two();
    t_idx();
    results();
  end
  initial begin
    repeat (5000) @(posedge CORE_CLK);
    bad_count++;
    results();
  end
endmodule
